// ===== design/rpfm_top.sv
`timescale 1ns/1ps
`include "rpfm_consts.svh"
// Notes on behaviour
// - Core held in reset while reset line low; fetch resumes at reset vector after release.
// - Internal reset sources drive the shared reset line low.
// - Sync clock output is system clock divided by a software-selected ratio.
// - After reset all six pins are pulled-up inputs with interrupts.
// - Alternate function on pins 0..3 routes TCK, TDI, TMS, TDO.
// - Debug-port enable bit in system control; clearing it disables JTAG.
// - Test data out driver enabled only in Shift-IR or Shift-DR.
// - Test mode select forced high when JTAG is disabled.
// - Pin 4 is GPIO with interrupt or SPI chip select.
// - Pin 5 is GPIO with interrupt or SPI serial clock.
module rpfm_top #(
  parameter int NPINS = `RPFM_NPINS,
  parameter int DIV_W = `RPFM_DIV_W
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe,
  output logic rst_pin_pullup,
  input wire logic int_reset_req,
  output logic core_reset,
  output logic core_fetch_vector,
  input wire logic [DIV_W-1:0] amp_sync_div_sel,
  output logic amp_sync_clock_out,
  input wire logic system_control_register_dbg_en,
  input wire logic [NPINS-1:0] port0_alt_en,
  input wire logic [NPINS-1:0] port0_gpio_out,
  input wire logic [NPINS-1:0] port0_gpio_dir,
  output logic [NPINS-1:0] port0_gpio_in,
  output logic [NPINS-1:0] port_pin_interrupt_input,
  input wire logic [NPINS-1:0] port0_pin_in,
  output logic [NPINS-1:0] port0_pin_out,
  output logic [NPINS-1:0] port0_pin_oe,
  output logic [NPINS-1:0] port0_pin_pullup,
  output logic jtag_tck,
  output logic jtag_tdi,
  output logic jtag_tms,
  input wire logic jtag_tdo,
  input wire logic [3:0] jtag_tap_state,
  output logic spi_ssel_in,
  input wire logic spi_ssel_out,
  input wire logic spi_ssel_oe,
  output logic spi_sclk_in,
  input wire logic spi_sclk_out,
  input wire logic spi_sclk_oe
);
  import rpfm_pkg::*;

  // ****************************************************************
  // Reset pin
  // ****************************************************************
  logic core_reset_q;
  logic fetch_q;

  assign rst_pin_out = 1'b0;
  assign rst_pin_oe = int_reset_req | ~resetn;
  assign rst_pin_pullup = 1'b1;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      core_reset_q <= 1'b1;
    end else begin
      core_reset_q <= ~rst_pin_in | int_reset_req;
    end
  end

  // The vector strobe marks the first cycle out of reset.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      fetch_q <= 1'b0;
    end else begin
      fetch_q <= core_reset_q & rst_pin_in & ~int_reset_req;
    end
  end

  assign core_reset = core_reset_q;
  assign core_fetch_vector = fetch_q;

  // ****************************************************************
  // Amplifier sync clock
  // ****************************************************************
  logic [15:0] div_cnt_q;
  logic [15:0] div_half;
  logic sync_q;

  // Select n gives a ratio of 2^(n+1); the half period is 2^n cycles.
  assign div_half = 16'h0001 << amp_sync_div_sel;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      div_cnt_q <= 16'h0000;
      sync_q <= 1'b0;
    end else if (div_cnt_q + 16'h0001 >= div_half) begin
      div_cnt_q <= 16'h0000;
      sync_q <= ~sync_q;
    end else begin
      div_cnt_q <= div_cnt_q + 16'h0001;
    end
  end

  assign amp_sync_clock_out = sync_q;

  // ****************************************************************
  // Alternate function selection
  // ****************************************************************
  logic [NPINS-1:0] alt_sel;
  logic [NPINS-1:0] alt_out;
  logic [NPINS-1:0] alt_oe;
  logic jtag_on;
  logic tdo_drive;

  assign jtag_on = system_control_register_dbg_en;

  always_comb begin
    alt_sel = port0_alt_en;
    if (!jtag_on) begin
      alt_sel[3:0] = 4'h0;
    end
  end

  assign tdo_drive = (jtag_tap_state == 4'(RPFM_TAP_SHIFT_IR))
                   | (jtag_tap_state == 4'(RPFM_TAP_SHIFT_DR));

  always_comb begin
    alt_out = '0;
    alt_oe = '0;
    alt_out[`RPFM_PIN_TDO] = jtag_tdo;
    alt_oe[`RPFM_PIN_TDO] = tdo_drive;
    alt_out[`RPFM_PIN_SSEL] = spi_ssel_out;
    alt_oe[`RPFM_PIN_SSEL] = spi_ssel_oe;
    alt_out[`RPFM_PIN_SCLK] = spi_sclk_out;
    alt_oe[`RPFM_PIN_SCLK] = spi_sclk_oe;
  end

  // ****************************************************************
  // Pad cells
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_pin
      rpfm_pin_cell u_cell (
        .alt_sel(alt_sel[gi]),
        .gpio_out(port0_gpio_out[gi]),
        .gpio_dir(port0_gpio_dir[gi]),
        .alt_out(alt_out[gi]),
        .alt_oe(alt_oe[gi]),
        .pad_in(port0_pin_in[gi]),
        .pad_out(port0_pin_out[gi]),
        .pad_oe(port0_pin_oe[gi]),
        .pad_pullup(port0_pin_pullup[gi]),
        .gpio_in(port0_gpio_in[gi]),
        .irq_in(port_pin_interrupt_input[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Inputs to the test and SPI units
  // ****************************************************************
  // JTAG inputs routed
  assign jtag_tck = alt_sel[`RPFM_PIN_TCK] & port0_pin_in[`RPFM_PIN_TCK];
  assign jtag_tdi = alt_sel[`RPFM_PIN_TDI] ? port0_pin_in[`RPFM_PIN_TDI] : 1'b1;
  assign jtag_tms = alt_sel[`RPFM_PIN_TMS] ? port0_pin_in[`RPFM_PIN_TMS] : 1'b1;
  assign spi_ssel_in = alt_sel[`RPFM_PIN_SSEL] ? port0_pin_in[`RPFM_PIN_SSEL] : 1'b1;
  assign spi_sclk_in = alt_sel[`RPFM_PIN_SCLK] & port0_pin_in[`RPFM_PIN_SCLK];
endmodule

// ===== shared/rpfm_consts.svh
`ifndef RPFM_CONSTS_SVH
`define RPFM_CONSTS_SVH

// Number of port-0 pins handled by the mux.
`define RPFM_NPINS 6
// Pin positions within port 0.
`define RPFM_PIN_TCK 0
`define RPFM_PIN_TDI 1
`define RPFM_PIN_TMS 2
`define RPFM_PIN_TDO 3
`define RPFM_PIN_SSEL 4
`define RPFM_PIN_SCLK 5
// Width of the sync clock divider select field.
`define RPFM_DIV_W 4
// Reset value of the sync clock divider select (divide by 2).
`define RPFM_DIV_RST 4'h0
// Reset value of the debug-port enable bit in the system control register.
`define RPFM_DBG_EN_RST 1'b1
// Reset value of the port-0 alternate function enables.
`define RPFM_ALT_RST 6'h00

`endif

// ===== shared/rpfm_pkg.sv
package rpfm_pkg;
  typedef enum logic [3:0] {
    RPFM_TAP_RESET,
    RPFM_TAP_IDLE,
    RPFM_TAP_SEL_DR,
    RPFM_TAP_CAP_DR,
    RPFM_TAP_SHIFT_DR,
    RPFM_TAP_EXIT1_DR,
    RPFM_TAP_PAUSE_DR,
    RPFM_TAP_EXIT2_DR,
    RPFM_TAP_UPD_DR,
    RPFM_TAP_SEL_IR,
    RPFM_TAP_CAP_IR,
    RPFM_TAP_SHIFT_IR,
    RPFM_TAP_EXIT1_IR,
    RPFM_TAP_PAUSE_IR,
    RPFM_TAP_EXIT2_IR,
    RPFM_TAP_UPD_IR
  } rpfm_tap_state_t;
endpackage

// ===== design/rpfm_pin_cell.sv
`timescale 1ns/1ps
// One port-0 pad: GPIO path, or alternate function path when selected.
module rpfm_pin_cell (
  input wire logic alt_sel,
  input wire logic gpio_out,
  input wire logic gpio_dir,
  input wire logic alt_out,
  input wire logic alt_oe,
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe,
  output logic pad_pullup,
  output logic gpio_in,
  output logic irq_in
);
  assign pad_out = alt_sel ? alt_out : gpio_out;
  assign pad_oe = alt_sel ? alt_oe : gpio_dir;
  assign pad_pullup = ~alt_sel & ~gpio_dir;
  assign gpio_in = alt_sel ? 1'b1 : pad_in;
  assign irq_in = alt_sel ? 1'b0 : pad_in;
endmodule

// ===== testbench/rpfm_top_monitor.sv
`timescale 1ns/1ps
module rpfm_top_monitor import rpfm_pkg::*; #(
  parameter int NPINS = 6,
  parameter int DIV_W = 4
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic rst_pin_in,
  input wire logic rst_pin_oe,
  input wire logic int_reset_req,
  input wire logic core_reset,
  input wire logic core_fetch_vector,
  input wire logic [DIV_W-1:0] amp_sync_div_sel,
  input wire logic amp_sync_clock_out,
  input wire logic system_control_register_dbg_en,
  input wire logic [NPINS-1:0] port0_alt_en,
  input wire logic [NPINS-1:0] port0_gpio_dir,
  input wire logic [NPINS-1:0] port0_pin_in,
  input wire logic [NPINS-1:0] port0_pin_oe,
  input wire logic [NPINS-1:0] port0_pin_pullup,
  input wire logic jtag_tms,
  input wire logic [3:0] jtag_tap_state,
  input wire logic spi_sclk_in,
  input wire logic spi_sclk_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence fetch_once;
    core_fetch_vector ##1 !core_fetch_vector;
  endsequence
  hold_low_a: assert property (!rst_pin_in |=> core_reset) else $error("core not held");
  fetch_pulse_a: assert property ($fell(core_reset) |-> fetch_once) else $error("no fetch");
  int_drive_a: assert property (int_reset_req |-> rst_pin_oe ##1 core_reset)
    else $error("internal reset not on pin");
  // The antecedent skips the first edge after reset, where the divider restarts.
  div_tick_a: assert property ($past(resetn) && amp_sync_div_sel == '0 && $stable(amp_sync_div_sel)
    |-> $changed(amp_sync_clock_out)) else $error("sync clock stuck");
  pad_default_a: assert property (port0_alt_en == '0 && port0_gpio_dir == '0
    |-> port0_pin_pullup == '1 && port0_pin_oe == '0) else $error("pad not pulled-up input");
  tdo_shift_a: assert property (port0_alt_en[3] && system_control_register_dbg_en
    |-> port0_pin_oe[3] == (jtag_tap_state inside {RPFM_TAP_SHIFT_DR, RPFM_TAP_SHIFT_IR}))
    else $error("tdo drive wrong");
  tms_gate_a: assert property (!system_control_register_dbg_en |-> jtag_tms)
    else $error("tms not high");
  sclk_route_a: assert property (port0_alt_en[5]
    |-> spi_sclk_in == port0_pin_in[5] && port0_pin_oe[5] == spi_sclk_oe) else $error("sclk");
endmodule
bind rpfm_top rpfm_top_monitor #(.NPINS(NPINS), .DIV_W(DIV_W)) rpfm_top_monitor_i (.*);

// ===== testbench/rpfm_pin_side.sv
`timescale 1ns/1ps
module rpfm_pin_side (
  input wire logic [5:0] pad_out,
  input wire logic [5:0] pad_oe,
  input wire logic [5:0] pad_pu,
  input wire logic rst_oe,
  input wire logic ext_rst,
  input wire logic [5:0] ext_drv,
  input wire logic [5:0] ext_val,
  output logic rst_in,
  output logic [5:0] pin_in
);
  assign rst_in = !(rst_oe || ext_rst);
  // A floating pad without pull-up reads the inverse of pad_out, so a lost pull-up shows while pad_out is 1.
  assign pin_in = (pad_oe & pad_out) | (~pad_oe & ext_drv & ext_val)
    | (~pad_oe & ~ext_drv & (pad_pu | ~pad_out));
endmodule

// ===== testbench/rpfm_top_tb.sv
`timescale 1ns/1ps
module rpfm_top_tb;
  logic core_clk, resetn, rst_pin_in, rst_pin_out, rst_pin_oe, rst_pin_pullup, int_reset_req;
  logic core_reset, core_fetch_vector, amp_sync_clock_out, system_control_register_dbg_en;
  logic [3:0] amp_sync_div_sel, jtag_tap_state;
  logic [5:0] port0_alt_en, port0_gpio_out, port0_gpio_dir, port0_gpio_in, ext_drv, ext_val;
  logic [5:0] port_pin_interrupt_input, port0_pin_in, port0_pin_out, port0_pin_oe, port0_pin_pullup;
  logic jtag_tck, jtag_tdi, jtag_tms, jtag_tdo, spi_ssel_in, spi_ssel_out, spi_ssel_oe;
  logic spi_sclk_in, spi_sclk_out, spi_sclk_oe, ext_rst, p;
  int n_fail = 0, checked = 0, cnt;
  rpfm_top rpfm_top_i (.*);
  rpfm_pin_side rpfm_pin_side_i (.pad_out(port0_pin_out), .pad_oe(port0_pin_oe),
    .pad_pu(port0_pin_pullup), .rst_oe(rst_pin_oe), .ext_rst(ext_rst), .ext_drv(ext_drv),
    .ext_val(ext_val), .rst_in(rst_pin_in), .pin_in(port0_pin_in));
  task cyc(int n = 1);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task ck(string nm, logic [5:0] e, logic [5:0] s);
    checked++;
    if (s !== e) begin
      $display("BAD %s exp %h got %h", nm, e, s);
      n_fail++;
    end
  endtask
  task give_verdict;
    if (n_fail == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task t_reset(logic by_int);
    {int_reset_req, ext_rst} = {by_int, !by_int};
    cyc(3);
    ck("hold", 2'b10, {core_reset, rst_pin_in});
    {int_reset_req, ext_rst} = 2'b00;
    cyc;
    ck("fetch", 2'b01, {core_reset, core_fetch_vector});
    cyc;
    ck("fetch_end", 2'b00, {core_reset, core_fetch_vector});
  endtask
  task t_div;
    for (int n = 0; n < 3; n++) begin
      amp_sync_div_sel = 4'(n);
      cyc(16);
      cnt = 0;
      repeat (16) begin
        p = amp_sync_clock_out;
        cyc;
        cnt += int'(amp_sync_clock_out !== p);
      end
      ck("sync_edges", 6'(16 >> n), 6'(cnt));
    end
  endtask
  task t_jtag;
    {port0_gpio_dir, port0_gpio_out, port0_alt_en} = {6'h3f, 6'h00, 6'h0f};
    {ext_drv, ext_val, jtag_tdo} = {6'h07, 6'h05, 1'b1};
    for (int s = 0; s < 16; s++) begin
      jtag_tap_state = 4'(s);
      cyc;
      ck("tdo_oe", 6'(s == 4 || s == 11), 6'(port0_pin_oe[3]));
    end
    ck("jtag_in", 3'b101, {jtag_tms, jtag_tdi, jtag_tck});
    ck("jtag_pads", 5'h10, {port0_pin_out[3], port0_pin_oe[3:0]});
    {system_control_register_dbg_en, ext_val} = {1'b0, 6'h01};
    cyc;
    ck("jtag_off", 5'h1f, {jtag_tms, port0_pin_oe[3:0]});
  endtask
  task t_spi;
    {port0_alt_en, port0_gpio_dir, port0_gpio_out} = {6'h30, 6'h30, 6'h30};
    {spi_ssel_oe, spi_ssel_out, spi_sclk_oe, ext_drv, ext_val} = {3'b100, 6'h20, 6'h20};
    cyc;
    ck("ssel_pad", 2'b10, {port0_pin_oe[4], port0_pin_out[4]});
    ck("sclk", 2'b10, {spi_sclk_in, port0_pin_oe[5]});
    ck("spi_in", 5'h0c, {spi_ssel_in, port0_gpio_in[5:4], port_pin_interrupt_input[5:4]});
  endtask
  initial begin
    core_clk = 0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    #1000000;
    n_fail++;
    give_verdict;
  end
  initial begin
    {resetn, int_reset_req, jtag_tdo, ext_rst, spi_ssel_out, spi_ssel_oe} = '0;
    {spi_sclk_out, spi_sclk_oe, amp_sync_div_sel, jtag_tap_state, ext_drv, ext_val} = '0;
    {port0_alt_en, port0_gpio_out, port0_gpio_dir, system_control_register_dbg_en} = 19'h1;
    cyc(10);
    resetn = 1;
    cyc(3);
    ck("pads", 6'h3f, port0_pin_pullup & ~port0_pin_oe & port_pin_interrupt_input);
    ck("gpio_in", 6'h3f, port0_gpio_in);
    ck("rst_pad", 2'b10, {rst_pin_pullup, rst_pin_out});
    t_reset(1'b0);
    t_reset(1'b1);
    t_div;
    t_jtag;
    t_spi;
    give_verdict;
  end
endmodule
